// ===== rsdc_pkg.sv
// package for the receive sync and demodulation configuration bank
package rsdc_pkg;

  // register offsets
  localparam logic [7:0] RSDC_OFS_SOF_HIGH  = 8'h5A;
  localparam logic [7:0] RSDC_OFS_SOF_LOW   = 8'h5B;
  localparam logic [7:0] RSDC_OFS_SYNC_CTL  = 8'h5C;
  localparam logic [7:0] RSDC_OFS_DEMOD_CTL = 8'h5D;
  localparam logic [7:0] RSDC_OFS_CORR_CTL  = 8'h5E;
  localparam logic [7:0] RSDC_OFS_TRIM      = 8'h5F;
  localparam logic [7:0] RSDC_OFS_REVISION  = 8'h7F;

  // reset values
  localparam logic [7:0] RSDC_RST_SOF_HIGH  = 8'h00;
  localparam logic [7:0] RSDC_RST_SOF_LOW   = 8'h00;
  localparam logic [7:0] RSDC_RST_SYNC_CTL  = 8'h00;
  localparam logic [7:0] RSDC_RST_DEMOD_CTL = 8'h00;
  localparam logic [7:0] RSDC_RST_CORR_CTL  = 8'h00;

  // writable masks: reserved bits read zero
  localparam logic [7:0] RSDC_MASK_DEMOD = 8'h3F;
  localparam logic [7:0] RSDC_MASK_CORR  = 8'hF8;

  // field positions
  localparam int RSDC_SYNC_LEN_LSB   = 4;
  localparam int RSDC_SYNC_NEG_BIT   = 3;
  localparam int RSDC_SYNC_HALF_BIT  = 2;
  localparam int RSDC_SYNC_TYPE_LSB  = 0;
  localparam int RSDC_DEM_AVG_BIT    = 5;
  localparam int RSDC_DEM_SQR_BIT    = 4;
  localparam int RSDC_DEM_PEAK_BIT   = 3;
  localparam int RSDC_DEM_SENSE_BIT  = 2;
  localparam int RSDC_DEM_FSK_BIT    = 1;
  localparam int RSDC_DEM_PHASE_SHIFT_DEMOD_BIT   = 0;
  localparam int RSDC_COR_FREQ_LSB   = 6;
  localparam int RSDC_COR_RATE_LSB   = 4;
  localparam int RSDC_COR_SHORT_BIT  = 3;

  // correlation window lengths
  localparam logic [6:0] RSDC_CORR_LEN_SHORT = 7'h20;
  localparam logic [6:0] RSDC_CORR_LEN_LONG  = 7'h40;

  // sync interpretation
  typedef enum logic [1:0] {
    RSDC_SYNC_BURST  = 2'h0,
    RSDC_SYNC_NIBBLE = 2'h1,
    RSDC_SYNC_START  = 2'h2,
    RSDC_SYNC_RSVD   = 2'h3
  } rsdc_sync_type_t;

  // subcarrier selection
  typedef enum logic [1:0] {
    RSDC_SC_212 = 2'h0,
    RSDC_SC_424 = 2'h1,
    RSDC_SC_848 = 2'h2
  } rsdc_subcarrier_t;

  // correlation rate
  typedef enum logic [1:0] {
    RSDC_RATE_FAST = 2'h0,
    RSDC_RATE_MID  = 2'h1,
    RSDC_RATE_SLOW = 2'h2,
    RSDC_RATE_RSVD = 2'h3
  } rsdc_rate_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsdc_req_t;

  // decoded sync configuration for the receiver
  typedef struct packed {
    logic [15:0]     pattern;
    logic [3:0]      pattern_length;
    logic            grid_from_falling_edge;
    logic            half_final_sync_bit;
    rsdc_sync_type_t sync_interpretation;
    logic            byte_resync;
    logic [3:0]      nibble_data;
    logic [3:0]      nibble_collision;
  } rsdc_sync_cfg_t;

  // decoded demodulation configuration
  typedef struct packed {
    logic             sample_averager_en;
    logic             squaring_filter_en;
    logic             grid_at_peak;
    logic             manchester_sense;
    logic             freq_shift_demod;
    logic             phase_shift_demod;
    rsdc_subcarrier_t subcarrier_select;
    rsdc_rate_t       correlation_rate;
    logic             correlation_window_short;
    logic [6:0]       correlation_length;
    logic [2:0]       average_group_log2;
  } rsdc_demod_cfg_t;

endpackage

// ===== rsdc_regs.sv
// register bank for receive sync pattern, demodulation and correlator setup
`timescale 1ns/1ps

// Function
// R01: read/write register holds upper byte of start-of-frame pattern.
// R02: read/write register holds lower byte, joined with upper into sixteen-bit pattern.
// R03: upper nibble of sync control sets count of valid pattern bits.
// R04: falling-edge bit makes bit grid come from first correlation falling edge.
// R05: half-final flag makes last sync bit half as long.
// R06: sync type zero treats all sixteen pattern bits as a burst.
// R07: sync type one treats each nibble as data plus collision flag.
// R08: when a nibble's collision flag is set, its data value is ignored.
// R09: sync type two resyncs at every byte start bit; type three reserved.
// R10: averager bit combines each four input samples into one value.
// R11: squaring bit reshapes converter samples toward rectangular form.
// R12: peak bit places grid at correlation maximum, else at minimum.
// R13: sense bit selects Manchester polarity; zero means subcarrier then none.
// R14: frequency-shift bit selects frequency-shift demodulation.
// R15: phase-shift bit selects binary phase-shift demodulation.
// R16: subcarrier field picks 212, 424 or 848 kHz.
// R17: rate field sets clocks per correlation; value three reserved.
// R18: window bit picks 32 correlation values when set, 64 when clear.
// R19: software keeps factory trim at its boot value though writable.
// R20: read-only revision register gives version high nibble, subversion low.
// R21: reserved demodulation and correlator bits read zero, ignore writes.
module rsdc_regs
  import rsdc_pkg::*;
#(
  parameter logic [3:0] VERSION    = 4'h1,  // arbitrary value
  parameter logic [3:0] SUBVERSION = 4'h0   // arbitrary value
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            arst_n,
  // factory trim loaded at boot
  input  wire logic [7:0]      trim_boot,
  input  wire logic            trim_load,
  // register port
  input  wire rsdc_req_t       req,
  output      logic [7:0]      rdata,
  // configuration to the receiver
  output      rsdc_sync_cfg_t  sync_cfg,
  output      rsdc_demod_cfg_t demod_cfg,
  output      logic [7:0]      receiver_factory_trim
);

  logic       rst_meta;
  logic       rst_n;
  logic [7:0] sof_pattern_high;
  logic [7:0] sof_pattern_low;
  logic [7:0] sync_control;
  logic [7:0] demod_control;
  logic [7:0] correlator_control;
  logic [7:0] next_rdata;
  logic [15:0] next_pattern;
  logic [3:0]  next_nib_data;
  logic [3:0]  next_nib_coll;

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pattern bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sof_pattern_high <= RSDC_RST_SOF_HIGH;
      sof_pattern_low  <= RSDC_RST_SOF_LOW;
    end else if (req.wr) begin
      if (req.addr == RSDC_OFS_SOF_HIGH) begin
        sof_pattern_high <= req.wdata; // R01
      end
      if (req.addr == RSDC_OFS_SOF_LOW) begin
        sof_pattern_low <= req.wdata; // R02
      end
    end
  end

  // sync, demodulation and correlator control
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_control       <= RSDC_RST_SYNC_CTL;
      demod_control      <= RSDC_RST_DEMOD_CTL;
      correlator_control <= RSDC_RST_CORR_CTL;
    end else if (req.wr) begin
      if (req.addr == RSDC_OFS_SYNC_CTL) begin
        sync_control <= req.wdata; // R03
      end
      if (req.addr == RSDC_OFS_DEMOD_CTL) begin
        demod_control <= req.wdata & RSDC_MASK_DEMOD; // R21
      end
      if (req.addr == RSDC_OFS_CORR_CTL) begin
        correlator_control <= req.wdata & RSDC_MASK_CORR; // R21
      end
    end
  end

  // factory trim: boot load, software write still possible
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receiver_factory_trim <= 8'h00;
    end else if (trim_load) begin
      receiver_factory_trim <= trim_boot; // R19
    end else if (req.wr && req.addr == RSDC_OFS_TRIM) begin
      receiver_factory_trim <= req.wdata;
    end
  end

  // read data mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (req.addr)
      RSDC_OFS_SOF_HIGH:  next_rdata = sof_pattern_high;
      RSDC_OFS_SOF_LOW:   next_rdata = sof_pattern_low;
      RSDC_OFS_SYNC_CTL:  next_rdata = sync_control;
      RSDC_OFS_DEMOD_CTL: next_rdata = demod_control;
      RSDC_OFS_CORR_CTL:  next_rdata = correlator_control;
      RSDC_OFS_TRIM:      next_rdata = receiver_factory_trim;
      RSDC_OFS_REVISION:  next_rdata = {VERSION, SUBVERSION}; // R20
      default:            next_rdata = 8'h00;
    endcase
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // pattern and nibble shaping, the same for every sync interpretation
  always_comb begin
    next_pattern  = {sof_pattern_high, sof_pattern_low}; // R02
    next_nib_data = 4'h0;
    next_nib_coll = 4'h0;
    for (int i = 0; i < 4; i++) begin
      next_nib_coll[i] = next_pattern[4*i];              // R07
      next_nib_data[i] = next_pattern[4*i+1] & ~next_pattern[4*i]; // R08
    end
  end

  // decoded sync configuration
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_cfg <= '0;
    end else begin
      sync_cfg.pattern                <= next_pattern; // R06
      sync_cfg.pattern_length         <= sync_control[RSDC_SYNC_LEN_LSB +: 4]; // R03
      sync_cfg.grid_from_falling_edge <= sync_control[RSDC_SYNC_NEG_BIT]; // R04
      sync_cfg.half_final_sync_bit    <= sync_control[RSDC_SYNC_HALF_BIT]; // R05
      sync_cfg.sync_interpretation    <=
        rsdc_sync_type_t'(sync_control[RSDC_SYNC_TYPE_LSB +: 2]);
      sync_cfg.byte_resync            <=
        (sync_control[RSDC_SYNC_TYPE_LSB +: 2] == RSDC_SYNC_START); // R09
      sync_cfg.nibble_data            <= next_nib_data; // R08
      sync_cfg.nibble_collision       <= next_nib_coll; // R07
    end
  end

  // decoded demodulation configuration
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      demod_cfg <= '0;
    end else begin
      demod_cfg.sample_averager_en <= demod_control[RSDC_DEM_AVG_BIT]; // R10
      demod_cfg.average_group_log2 <=
        demod_control[RSDC_DEM_AVG_BIT] ? 3'h2 : 3'h0; // R10
      demod_cfg.squaring_filter_en <= demod_control[RSDC_DEM_SQR_BIT]; // R11
      demod_cfg.grid_at_peak       <= demod_control[RSDC_DEM_PEAK_BIT]; // R12
      demod_cfg.manchester_sense   <= demod_control[RSDC_DEM_SENSE_BIT]; // R13
      demod_cfg.freq_shift_demod   <= demod_control[RSDC_DEM_FSK_BIT]; // R14
      demod_cfg.phase_shift_demod  <= demod_control[RSDC_DEM_PHASE_SHIFT_DEMOD_BIT]; // R15
      demod_cfg.subcarrier_select  <=
        correlator_control[RSDC_COR_FREQ_LSB + 1] ? RSDC_SC_848 :
        rsdc_subcarrier_t'(correlator_control[RSDC_COR_FREQ_LSB +: 2]); // R16
      demod_cfg.correlation_rate   <=
        rsdc_rate_t'(correlator_control[RSDC_COR_RATE_LSB +: 2]); // R17
      demod_cfg.correlation_window_short <= correlator_control[RSDC_COR_SHORT_BIT];
      demod_cfg.correlation_length <= correlator_control[RSDC_COR_SHORT_BIT] ?
        RSDC_CORR_LEN_SHORT : RSDC_CORR_LEN_LONG; // R18
    end
  end

endmodule // rsdc_regs

// ===== rsdc_regs_monitor.sv
// bound checker for the receive configuration register bank
`timescale 1ns/1ps
module rsdc_regs_monitor
  import rsdc_pkg::*;
#(
  parameter logic [3:0] VERSION    = 4'h1,  // arbitrary value
  parameter logic [3:0] SUBVERSION = 4'h0   // arbitrary value
) (
  // clock and reset
  input wire logic            mclk,
  input wire logic            arst_n,
  // trim and register port
  input wire logic [7:0]      trim_boot,
  input wire logic            trim_load,
  input wire rsdc_req_t       req,
  input wire logic [7:0]      rdata,
  // decoded configuration
  input wire rsdc_sync_cfg_t  sync_cfg,
  input wire rsdc_demod_cfg_t demod_cfg,
  input wire logic [7:0]      receiver_factory_trim
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // a write reaches the decoded outputs two edges after it is taken
  a_high_byte_load: assert property (req.wr && req.addr == RSDC_OFS_SOF_HIGH |-> ##2
    sync_cfg.pattern[15:8] == $past(req.wdata, 2)) else $error("pattern high byte wrong");
  a_low_byte_load: assert property (req.wr && req.addr == RSDC_OFS_SOF_LOW |-> ##2
    sync_cfg.pattern[7:0] == $past(req.wdata, 2)) else $error("pattern low byte wrong");
  a_sync_fields_load: assert property (req.wr && req.addr == RSDC_OFS_SYNC_CTL |-> ##2
    {sync_cfg.pattern_length, sync_cfg.grid_from_falling_edge, sync_cfg.half_final_sync_bit,
     sync_cfg.sync_interpretation} == $past(req.wdata, 2)) else $error("sync fields wrong");
  a_byte_resync_type: assert property (sync_cfg.byte_resync ==
    (sync_cfg.sync_interpretation == RSDC_SYNC_START)) else $error("byte resync wrong");
  a_collision_masks_data: assert property ((sync_cfg.nibble_data & sync_cfg.nibble_collision)
    == 4'h0) else $error("collided nibble keeps data");
  a_demod_bits_load: assert property (req.wr && req.addr == RSDC_OFS_DEMOD_CTL |-> ##2
    {demod_cfg.sample_averager_en, demod_cfg.squaring_filter_en, demod_cfg.grid_at_peak,
     demod_cfg.manchester_sense, demod_cfg.freq_shift_demod, demod_cfg.phase_shift_demod}
    == $past(req.wdata[5:0], 2)) else $error("demod bits wrong");
  a_window_length: assert property (req.wr && req.addr == RSDC_OFS_CORR_CTL |-> ##2
    demod_cfg.correlation_length == ($past(req.wdata[3], 2) ? RSDC_CORR_LEN_SHORT
    : RSDC_CORR_LEN_LONG)) else $error("correlation length wrong");
  a_subcarrier_map: assert property (req.wr && req.addr == RSDC_OFS_CORR_CTL |-> ##2
    demod_cfg.subcarrier_select == ($past(req.wdata[7], 2) ? 2'h2 : 2'h0 | $past(req.wdata[6], 2)))
    else $error("subcarrier wrong");
  a_revision_read: assert property (req.rd && req.addr == RSDC_OFS_REVISION |=>
    rdata == {VERSION, SUBVERSION}) else $error("revision read wrong");
  a_rdata_quiet: assert property (!req.rd |=> rdata == 8'h00) else $error("rdata not zero");
endmodule // rsdc_regs_monitor

bind rsdc_regs rsdc_regs_monitor #(.VERSION(VERSION), .SUBVERSION(SUBVERSION)) u_mon (
  .mclk(mclk), .arst_n(arst_n), .trim_boot(trim_boot), .trim_load(trim_load), .req(req),
  .rdata(rdata), .sync_cfg(sync_cfg), .demod_cfg(demod_cfg),
  .receiver_factory_trim(receiver_factory_trim));

// ===== rsdc_regs_bench.sv
// self-checking bench for the receive configuration register bank
`timescale 1ns/1ps
module rsdc_regs_bench
  import rsdc_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [7:0] e;} rsdc_row_t;
  logic            mclk;
  logic            arst_n;
  logic [7:0]      trim_boot;
  logic            trim_load;
  rsdc_req_t       req;
  logic [7:0]      rdata;
  logic [7:0]      got;
  logic [7:0]      trim;
  rsdc_sync_cfg_t  sync_cfg;
  rsdc_demod_cfg_t demod_cfg;
  int              bad_count;
  int              num_checks;
  // address, write value, value after reset, value read back
  rsdc_row_t rows [9] = '{'{8'h5A, 8'hA5, 8'h00, 8'hA5}, '{8'h5B, 8'h3C, 8'h00, 8'h3C},
    '{8'h5C, 8'hF7, 8'h00, 8'hF7}, '{8'h5D, 8'hFF, 8'h00, 8'h3F}, '{8'h5E, 8'hFF, 8'h00, 8'hF8},
    '{8'h5F, 8'h9A, 8'hC3, 8'h9A}, '{8'h7F, 8'h55, 8'h10, 8'h10}, '{8'h60, 8'h77, 8'h00, 8'h00},
    '{8'h00, 8'hFF, 8'h00, 8'h00}};

  rsdc_regs #(.VERSION(4'h1), .SUBVERSION(4'h0)) dut (.mclk(mclk), .arst_n(arst_n),
    .trim_boot(trim_boot), .trim_load(trim_load), .req(req), .rdata(rdata),
    .sync_cfg(sync_cfg), .demod_cfg(demod_cfg), .receiver_factory_trim(trim));

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // bus cycles and comparison; the bus and settle tasks start and end at a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req <= '0;
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask
  task automatic settle();
    req <= '0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    arst_n = 1'b0;
    req = '0;
    trim_load = 1'b0;
    trim_boot = 8'hC3;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    trim_load <= 1'b1;
    wr_reg(8'h5F, 8'h11);
    trim_load <= 1'b0;
    chk("boot trim", 16'h00C3, 16'(trim));
    foreach (rows[i]) begin
      rd_reg(rows[i].a, got);
      chk("reset value", 16'(rows[i].r), 16'(got));
      wr_reg(rows[i].a, rows[i].w);
      rd_reg(rows[i].a, got);
      chk("readback", 16'(rows[i].e), 16'(got));
    end
    settle();
    chk("pattern", 16'hA53C, sync_cfg.pattern);
    chk("nibble data", 16'h0008, 16'(sync_cfg.nibble_data));
    chk("nibble collision", 16'h0006, 16'(sync_cfg.nibble_collision));
    chk("average group", 16'h0002, 16'(demod_cfg.average_group_log2));
    $display("register table test done");
    for (int t = 0; t < 4; t++) begin
      wr_reg(8'h5C, 8'(t));
      settle();
      chk("sync type", 16'(t), 16'(sync_cfg.sync_interpretation));
      chk("byte resync", 16'(t == 2), 16'(sync_cfg.byte_resync));
    end
    for (int v = 0; v < 4; v++) begin
      wr_reg(8'h5E, {2'(v), 2'(v), v[0], 3'h0});
      settle();
      chk("subcarrier", 16'(v == 3 ? 2 : v), 16'(demod_cfg.subcarrier_select));
      chk("rate", 16'(v), 16'(demod_cfg.correlation_rate));
      chk("length", 16'(v[0] ? 32 : 64), 16'(demod_cfg.correlation_length));
    end
    wr_reg(8'h5D, 8'h15);
    settle();
    chk("demod bits", 16'h0015, 16'({demod_cfg.sample_averager_en, demod_cfg.squaring_filter_en,
      demod_cfg.grid_at_peak, demod_cfg.manchester_sense, demod_cfg.freq_shift_demod,
      demod_cfg.phase_shift_demod}));
    $display("field decode test done");
    arst_n <= 1'b0;
    @(negedge mclk);
    chk("pattern in reset", 16'h0000, sync_cfg.pattern);
    @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_reg(8'h5C, got);
    chk("sync after reset", 16'h0000, 16'(got));
    settle();
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule // rsdc_regs_bench
